// [sois_pkg.sv]
/*
  sois_pkg: constants and types shared by the scalar operand input stage.
  Assumes: included before the interface and all modules; nothing imported.
*/
`default_nettype none
package sois_pkg;
  // data path widths
  localparam int DATA_W = 64;
  localparam int OPC_W = 8;
  localparam int WADDR_W = 3;
  localparam int OADDR_W = 24;
  localparam int WSIZE_W = 2;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
  localparam logic [OADDR_W-1:0] OADDR_RST = 24'h0;
  localparam logic [OPC_W-1:0] OPC_RST = 8'h0;
  localparam logic [WSIZE_W-1:0] WSIZE_RST = 2'h0;
  localparam logic [WADDR_W-1:0] WADDR_RST = 3'h0;
  // apb register offsets (byte addresses)
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] CTRL_OFF = 8'h04;
  localparam logic [7:0] INL_LO_OFF = 8'h08;
  localparam logic [7:0] XADDR_OFF = 8'h0c;
  // status field positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_DPRES = 1;
  localparam int ST_INL_FULL = 2;
  localparam int ST_REG_FULL = 3;
  localparam int ST_XAVAL = 4;
  localparam int ST_YFIRST = 5;
  localparam int ST_XVAL = 6;
  localparam int ST_XREQ = 7;
  localparam int ST_STATE = 8;
  // control field: freeze stops acceptance of new commands
  localparam int CT_FREEZE = 0;
  localparam logic CTRL_RST = 1'b0;
  // controller states, one-hot
  typedef enum logic [2:0] {
    SOIS_IDLE = 3'b001,
    SOIS_FETCH = 3'b010,
    SOIS_HOLD = 3'b100
  } sois_state_e;
endpackage : sois_pkg
`default_nettype wire

// [sois_fetch_if.sv]
/*
  sois_fetch_if: octet fetch request path from the input stage to the memory requester.
  Assumes: one clock domain; the requester answers with a one-cycle return pulse.
*/
`timescale 1ns/100ps
`default_nettype none
interface sois_fetch_if;
  logic req;
  logic [sois_pkg::OADDR_W-1:0] addr;
  logic done;
  modport ctl (output req, output addr, input done);
  modport req_side (input req, input addr, output done);
endinterface : sois_fetch_if
`default_nettype wire

// [sois_fetch_req.sv]
/*
  sois_fetch_req: holds the x octet fetch request until memory returns the octet.
  Assumes: mem_done pulses once per granted fetch; start and done never coincide.
*/
`timescale 1ns/100ps
`default_nettype none
module sois_fetch_req (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  input wire logic start,
  input wire logic [sois_pkg::OADDR_W-1:0] start_addr,
  // memory side
  input wire logic mem_done,
  sois_fetch_if.ctl fif
);
  logic req_ff;
  logic [sois_pkg::OADDR_W-1:0] addr_ff;

  // request stays up until the octet returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
    end else if (start) begin
      req_ff <= 1'b1;
    end else if (mem_done) begin
      req_ff <= 1'b0;
    end
  end

  // fetch address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= sois_pkg::OADDR_RST;
    end else if (start) begin
      addr_ff <= start_addr;
    end
  end

  assign fif.req = req_ff;
  assign fif.addr = addr_ff;
endmodule // sois_fetch_req
`default_nettype wire

// [sois_input_stage.sv]
/*
  sois_input_stage: level 5 scalar operand input stage controller with apb status.
  Assumes: issue unit holds its command until accept is seen; level 6 and the
  memory requester are logic in the same clock domain.
*/
// Added by the designer: the register addresses and register access over APB.
// Overview of operation
// - only scalar loads are handled here; vector loads bypass this block.
// - when the stage is idle it takes an immediate, x buffer or y buffer load.
// - an immediate load copies the operand, sets immediate full and data present.
// - a present register operand is copied in and sets register full.
// - an immediate load sets active, passes opcode and word size, and accepts.
// - an x buffer load steers the addressed x word into the level 6 output.
// - an x buffer load copies the word address, sets x address valid, clears y first.
// - y first chooses which buffer receives the next octet from memory.
// - a needed fetch loads the fetch address, raises the request, clears x valid.
// - after a fetch the stage is active and waits for the octet to return.
// - actions are qualified by level 5 and 6 status and issue unit bits.
// - with no fetch and x valid the stage waits while x update is pending.
// - the stage passes on only with data present, select next and level 6 accept.
`timescale 1ns/100ps
`default_nettype none
module sois_input_stage #(
  parameter int DATA_W = sois_pkg::DATA_W,
  parameter int OPC_W = sois_pkg::OPC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // issue unit level 3/4 command
  input wire logic immediate_ctl_bit,
  input wire logic x_buffer_load_bit,
  input wire logic y_buffer_load_bit,
  input wire logic x_fetch_needed_bit,
  input wire logic reg_operand_present_bit,
  input wire logic x_update_pending,
  input wire logic [DATA_W-1:0] issue_addr_operand_reg,
  input wire logic [DATA_W-1:0] issue_reg_operand,
  input wire logic [OPC_W-1:0] issue_opcode_y,
  input wire logic [sois_pkg::WSIZE_W-1:0] issue_word_size,
  output logic input_accept_to_issue,
  // level 6 side
  input wire logic select_next_signal,
  input wire logic level6_accept,
  input wire logic [DATA_W-1:0] x_buffer_word,
  output logic level6_load,
  output logic [DATA_W-1:0] level6_output_reg,
  output logic [DATA_W-1:0] reg_operand_ff_out,
  output logic [OPC_W-1:0] microcode_addr,
  output logic [sois_pkg::WSIZE_W-1:0] word_size_sel,
  output logic [sois_pkg::WADDR_W-1:0] x_word_select,
  output logic y_first_pointer,
  // memory requester
  input wire logic mem_octet_done,
  output logic x_fetch_request,
  output logic [sois_pkg::OADDR_W-1:0] x_fetch_addr_reg
);
  ////////////////////////////////////////////////////////////////////////////
  sois_pkg::sois_state_e state_ff, nxt_state;
  logic input_active_flag_ff, input_data_present_ff, immediate_full_flag_ff;
  logic reg_full_flag_ff, x_addr_valid_flag_ff, y_first_ff, x_buffer_valid_flag_ff;
  logic [DATA_W-1:0] immediate_holder_ff, reg_op_ff, out_ff;
  logic [sois_pkg::WADDR_W-1:0] x_operand_addr_reg_ff;
  logic [OPC_W-1:0] opc_ff;
  logic [sois_pkg::WSIZE_W-1:0] wsize_ff;
  logic ctrl_freeze_ff;
  logic pass_on, can_take, take_cmd, take_inline, take_x, take_y, start_fetch, x_ready;
  logic x_wait_done;
  sois_fetch_if fif ();

  ////////////////////////////////////////////////////////////////////////////
  // the stage hands off only when all four level 5/6 conditions agree
  assign pass_on = input_active_flag_ff && input_data_present_ff
                   && select_next_signal && level6_accept;
  // idle, or emptying this edge, frees the stage; software freeze holds it
  assign can_take = (!input_active_flag_ff || pass_on) && !ctrl_freeze_ff;
  // vector commands never arrive on these bits, so only scalar paths exist
  assign take_inline = can_take && immediate_ctl_bit;
  assign take_x = can_take && !immediate_ctl_bit && x_buffer_load_bit;
  // y path: accepted as a plain load, its buffer detail lives elsewhere
  assign take_y = can_take && !immediate_ctl_bit && !x_buffer_load_bit
                  && y_buffer_load_bit;
  assign take_cmd = take_inline || take_x || take_y;
  assign start_fetch = take_x && x_fetch_needed_bit;
  // x data usable only when valid and no update is still running
  assign x_ready = x_buffer_valid_flag_ff && !x_update_pending;
  assign x_wait_done = (state_ff == sois_pkg::SOIS_HOLD) && x_ready;
  assign input_accept_to_issue = take_cmd;
  assign level6_load = pass_on;

  ////////////////////////////////////////////////////////////////////////////
  // controller state: idle, waiting on a fetch, or holding for x update
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sois_pkg::SOIS_IDLE: begin
        if (start_fetch) begin
          nxt_state = sois_pkg::SOIS_FETCH;
        end else if (take_x && !x_ready) begin
          nxt_state = sois_pkg::SOIS_HOLD;
        end
      end
      sois_pkg::SOIS_FETCH: begin
        if (mem_octet_done) begin
          nxt_state = sois_pkg::SOIS_HOLD;
        end
      end
      sois_pkg::SOIS_HOLD: begin
        if (x_ready) begin
          nxt_state = sois_pkg::SOIS_IDLE;
        end
      end
      default: nxt_state = sois_pkg::SOIS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= sois_pkg::SOIS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // activity flag: set on any accepted command, cleared when handed on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_active_flag_ff <= 1'b0;
    end else if (take_cmd) begin
      input_active_flag_ff <= 1'b1;
    end else if (pass_on) begin
      input_active_flag_ff <= 1'b0;
    end
  end

  // data present: immediate at once, x path once octet is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_data_present_ff <= 1'b0;
    end else if (take_inline || take_y || (take_x && !x_fetch_needed_bit && x_ready)) begin
      input_data_present_ff <= 1'b1;
    end else if (x_wait_done) begin
      input_data_present_ff <= 1'b1;
    end else if (pass_on || take_x) begin
      input_data_present_ff <= 1'b0;
    end
  end

  // immediate holder and full flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      immediate_holder_ff <= DATA_W'(sois_pkg::DATA_RST);
      immediate_full_flag_ff <= 1'b0;
    end else if (take_inline) begin
      immediate_holder_ff <= issue_addr_operand_reg;
      immediate_full_flag_ff <= 1'b1;
    end else if (pass_on) begin
      immediate_full_flag_ff <= 1'b0;
    end
  end

  // register operand holder: loaded on any accepted command that carries one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_op_ff <= DATA_W'(sois_pkg::DATA_RST);
      reg_full_flag_ff <= 1'b0;
    end else if (take_cmd && reg_operand_present_bit) begin
      reg_op_ff <= issue_reg_operand;
      reg_full_flag_ff <= 1'b1;
    end else if (pass_on) begin
      reg_full_flag_ff <= 1'b0;
    end
  end

  // opcode and word size follow every accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_ff <= OPC_W'(sois_pkg::OPC_RST);
      wsize_ff <= sois_pkg::WSIZE_RST;
    end else if (take_cmd) begin
      opc_ff <= issue_opcode_y;
      wsize_ff <= issue_word_size;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // x word address, its valid flag and the y first pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_operand_addr_reg_ff <= sois_pkg::WADDR_RST;
      x_addr_valid_flag_ff <= 1'b0;
      y_first_ff <= 1'b0;
    end else if (take_x) begin
      x_operand_addr_reg_ff <= issue_addr_operand_reg[sois_pkg::WADDR_W-1:0];
      x_addr_valid_flag_ff <= 1'b1;
      y_first_ff <= 1'b0;
    end else begin
      // a y load points the next memory octet at the y buffer
      if (take_y) begin
        y_first_ff <= 1'b1;
      end
      if (pass_on) begin
        x_addr_valid_flag_ff <= 1'b0;
      end
    end
  end

  // x buffer valid: cleared when a fetch starts, set when the octet lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_buffer_valid_flag_ff <= 1'b0;
    end else if (start_fetch) begin
      x_buffer_valid_flag_ff <= 1'b0;
    end else if (fif.done && !y_first_ff) begin
      x_buffer_valid_flag_ff <= 1'b1;
    end
  end

  // level 6 output: x word when the x address is live, else immediate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= DATA_W'(sois_pkg::DATA_RST);
    end else if (pass_on) begin
      out_ff <= x_addr_valid_flag_ff ? x_buffer_word : immediate_holder_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch request held in its own small block
  sois_fetch_req u_fetch (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_fetch),
    .start_addr(issue_addr_operand_reg[sois_pkg::OADDR_W-1:0]),
    .mem_done(mem_octet_done),
    .fif(fif.ctl)
  );
  assign x_fetch_request = fif.req;
  assign x_fetch_addr_reg = fif.addr;
  assign fif.done = mem_octet_done;

  assign level6_output_reg = out_ff;
  assign reg_operand_ff_out = reg_op_ff;
  assign microcode_addr = opc_ff;
  assign word_size_sel = wsize_ff;
  assign x_word_select = x_operand_addr_reg_ff;
  assign y_first_pointer = y_first_ff;

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait states; unmapped reads give zero and flag an error
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_freeze_ff <= sois_pkg::CTRL_RST;
    end else if (psel && penable && pwrite && paddr == sois_pkg::CTRL_OFF) begin
      ctrl_freeze_ff <= pwdata[sois_pkg::CT_FREEZE];
    end
  end

  // read mux, decoded by address chain
  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    if (paddr == sois_pkg::STATUS_OFF) begin
      prdata[sois_pkg::ST_ACTIVE] = input_active_flag_ff;
      prdata[sois_pkg::ST_DPRES] = input_data_present_ff;
      prdata[sois_pkg::ST_INL_FULL] = immediate_full_flag_ff;
      prdata[sois_pkg::ST_REG_FULL] = reg_full_flag_ff;
      prdata[sois_pkg::ST_XAVAL] = x_addr_valid_flag_ff;
      prdata[sois_pkg::ST_YFIRST] = y_first_ff;
      prdata[sois_pkg::ST_XVAL] = x_buffer_valid_flag_ff;
      prdata[sois_pkg::ST_XREQ] = fif.req;
      prdata[sois_pkg::ST_STATE +: 3] = state_ff;
    end else if (paddr == sois_pkg::CTRL_OFF) begin
      prdata[sois_pkg::CT_FREEZE] = ctrl_freeze_ff;
    end else if (paddr == sois_pkg::INL_LO_OFF) begin
      prdata = immediate_holder_ff[31:0];
    end else if (paddr == sois_pkg::XADDR_OFF) begin
      prdata[sois_pkg::WADDR_W-1:0] = x_operand_addr_reg_ff;
    end else begin
      pslverr = psel && penable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_fetch_taken;
    start_fetch;
  endsequence

  handoff_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    level6_load |-> input_data_present_ff && select_next_signal && level6_accept)
    else $error("hand-off without all conditions");
  inline_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_inline |=> immediate_full_flag_ff && input_data_present_ff
      && immediate_holder_ff == $past(issue_addr_operand_reg))
    else $error("immediate not captured");
  reg_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_cmd && reg_operand_present_bit |=> reg_full_flag_ff
      && reg_op_ff == $past(issue_reg_operand))
    else $error("register operand not captured");
  accept_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    input_accept_to_issue |=> input_active_flag_ff && opc_ff == $past(issue_opcode_y))
    else $error("accept without activity");
  xaddr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_x |=> x_addr_valid_flag_ff && !y_first_ff)
    else $error("x address flags wrong");
  fetch_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_fetch_taken |=> x_fetch_request && !x_buffer_valid_flag_ff)
    else $error("fetch not raised");
  fetch_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == sois_pkg::SOIS_FETCH |-> !input_data_present_ff && !level6_load)
    else $error("level 5 used during fetch");
  xup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == sois_pkg::SOIS_HOLD && x_update_pending |=> !input_data_present_ff)
    else $error("data present during x update");
  word_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    level6_load && x_addr_valid_flag_ff |=> level6_output_reg == $past(x_buffer_word))
    else $error("x word not loaded to level 6");

  // hold ends on the first edge with x valid and no update running
  sequence s_hold_release;
    (state_ff == sois_pkg::SOIS_HOLD) && x_ready;
  endsequence

  hold_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_hold_release |=> input_data_present_ff && state_ff == sois_pkg::SOIS_IDLE)
    else $error("hold not released");
  handoff_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    level6_load && !input_accept_to_issue |=> !input_active_flag_ff && !input_data_present_ff)
    else $error("stage not emptied by hand-off");
  accept_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    input_active_flag_ff && !level6_load |-> !input_accept_to_issue)
    else $error("command taken while stage busy");
  fetch_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_fetch_taken |=> x_fetch_addr_reg
      == $past(issue_addr_operand_reg[sois_pkg::OADDR_W-1:0]))
    else $error("fetch address not captured");
  xval_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    mem_octet_done && !y_first_pointer && !start_fetch |=> x_buffer_valid_flag_ff)
    else $error("returned octet not marked valid");
  yfirst_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_y |=> y_first_pointer)
    else $error("y first not set by y load");
endmodule // sois_input_stage
`default_nettype wire

// [sois_mem_model.sv]
/*
  sois_mem_model: memory requester and x buffer seen from the input stage.
  Assumes: one clock; a raised request is held until the octet returns.
*/
`timescale 1ns/100ps
`default_nettype none
module sois_mem_model #(
  parameter int LAT = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fetch path
  input wire logic x_fetch_request,
  output logic mem_octet_done,
  // x buffer read port
  input wire logic [sois_pkg::WADDR_W-1:0] x_word_select,
  output logic [sois_pkg::DATA_W-1:0] x_buffer_word
);
  logic [7:0] cnt_ff;
  logic served_ff;
  logic done_ff;
  ////////////////////////////////////////////////////////////////////////
  // one return pulse per request; served blocks a second pulse while the
  // stage still shows the old request in the cycle after the return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
      served_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!x_fetch_request) begin
        cnt_ff <= 8'h00;
        served_ff <= 1'b0;
      end else if (!served_ff) begin
        if (cnt_ff == 8'(LAT - 1)) begin
          done_ff <= 1'b1;
          served_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
  assign mem_octet_done = done_ff;
  // word value carries its own index so a wrong select shows at level 6
  assign x_buffer_word = {8'h5a, 53'h0, x_word_select};
endmodule // sois_mem_model
`default_nettype wire

// [scalar_operand_input_stage_tb_top.sv]
/*
  scalar_operand_input_stage_tb_top: drives issue, level 6 and apb sides.
  Assumes: design and memory model compiled first; 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module scalar_operand_input_stage_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic inl_b = 1'b0;
  logic xl_b = 1'b0;
  logic yl_b = 1'b0;
  logic fe_b = 1'b0;
  logic rp_b = 1'b0;
  logic upd_pend = 1'b1;
  logic [63:0] aop = 64'h0;
  logic [63:0] rop = 64'hdead_beef_0bad_f00d;
  logic [7:0] opc = 8'h3c;
  logic [1:0] ws = 2'h2;
  logic acc;
  logic sn = 1'b0;
  logic l6a = 1'b0;
  logic [63:0] xw;
  logic l6_load;
  logic [63:0] l6_out;
  logic [63:0] reg_out;
  logic [7:0] uc_addr;
  logic [1:0] ws_sel;
  logic [2:0] xsel;
  logic yfirst;
  logic done;
  logic xreq;
  logic [23:0] xaddr;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int n_tests = 0;
  ////////////////////////////////////////////////////////////////////////
  always #5 pclk = ~pclk;
  sois_input_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .immediate_ctl_bit(inl_b), .x_buffer_load_bit(xl_b), .y_buffer_load_bit(yl_b),
    .x_fetch_needed_bit(fe_b), .reg_operand_present_bit(rp_b), .x_update_pending(upd_pend),
    .issue_addr_operand_reg(aop), .issue_reg_operand(rop), .issue_opcode_y(opc),
    .issue_word_size(ws), .input_accept_to_issue(acc), .select_next_signal(sn),
    .level6_accept(l6a), .x_buffer_word(xw), .level6_load(l6_load),
    .level6_output_reg(l6_out), .reg_operand_ff_out(reg_out), .microcode_addr(uc_addr),
    .word_size_sel(ws_sel), .x_word_select(xsel), .y_first_pointer(yfirst),
    .mem_octet_done(done), .x_fetch_request(xreq), .x_fetch_addr_reg(xaddr));
  sois_mem_model #(.LAT(8)) mem (.pclk(pclk), .presetn(presetn),
    .x_fetch_request(xreq), .mem_octet_done(done), .x_word_select(xsel),
    .x_buffer_word(xw));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
    check(err, 1'b0);
    check(pready, 1'b1);
  endtask
  // issue command bits in order immediate, x, y, fetch, register present
  task automatic cmd_set(input logic [4:0] b, input logic [63:0] a);
    @(posedge pclk);
    {inl_b, xl_b, yl_b, fe_b, rp_b} <= b;
    aop <= a;
  endtask
  task automatic cmd_wait;
    int n;
    n = 0;
    @(negedge pclk);
    while (acc !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    check(n < 200, 1'b1);
    @(posedge pclk);
    {inl_b, xl_b, yl_b, fe_b, rp_b} <= 5'h0;
  endtask
  task automatic refused;
    repeat (3) begin
      @(negedge pclk);
      check(acc, 1'b0);
    end
  endtask
  task automatic pass_on(input logic [63:0] w, input logic cw);
    @(posedge pclk);
    sn <= 1'b1;
    l6a <= 1'b1;
    @(negedge pclk);
    check(l6_load, 1'b1);
    @(posedge pclk);
    sn <= 1'b0;
    l6a <= 1'b0;
    @(negedge pclk);
    if (cw) check(l6_out, w);
    check(l6_load, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog: whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(sois_pkg::STATUS_OFF, 32'h0000_0100, 32'hffff_ffff);
    rd_chk(sois_pkg::CTRL_OFF, 32'h0, 32'hffff_ffff);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    // x load needing an octet, update pending when it returns
    cmd_set(5'b01010, 64'h0000_0000_0012_3456);
    cmd_wait;
    @(negedge pclk);
    check({xreq, xaddr}, {1'b1, 24'h123456});
    check({yfirst, xsel}, {1'b0, 3'h6});
    rd_chk(sois_pkg::STATUS_OFF, 32'h0000_0291, 32'hffff_ffff);
    n = 0;
    while (xreq !== 1'b0 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    check(n < 100, 1'b1);
    rd_chk(sois_pkg::STATUS_OFF, 32'h0000_0451, 32'hffff_ffff);
    @(posedge pclk);
    upd_pend <= 1'b0;
    rd_chk(sois_pkg::STATUS_OFF, 32'h0000_0153, 32'hffff_ffff);
    pass_on(64'h5a00_0000_0000_0006, 1'b1);
    // immediate with register operand, then a refused and a back-to-back x load
    cmd_set(5'b10001, 64'h1122_3344_5566_7788);
    // fresh opcode and size so a stale copy from the x load cannot pass
    opc <= 8'hc3;
    ws <= 2'h1;
    cmd_wait;
    @(negedge pclk);
    check({uc_addr, ws_sel}, {8'hc3, 2'h1});
    check(reg_out, 64'hdead_beef_0bad_f00d);
    rd_chk(sois_pkg::STATUS_OFF, 32'h0f, 32'h0f);
    rd_chk(sois_pkg::INL_LO_OFF, 32'h5566_7788, 32'hffff_ffff);
    cmd_set(5'b01000, 64'h3);
    refused;
    @(posedge pclk);
    sn <= 1'b1;
    l6a <= 1'b1;
    @(negedge pclk);
    check({l6_load, acc}, 2'b11);
    @(posedge pclk);
    sn <= 1'b0;
    l6a <= 1'b0;
    {inl_b, xl_b, yl_b, fe_b, rp_b} <= 5'h0;
    @(negedge pclk);
    check({yfirst, xsel}, {1'b0, 3'h3});
    check(l6_out, 64'h1122_3344_5566_7788);
    rd_chk(sois_pkg::STATUS_OFF, 32'h13, 32'h13);
    pass_on(64'h5a00_0000_0000_0003, 1'b1);
    // y load
    cmd_set(5'b00100, 64'h0);
    cmd_wait;
    @(negedge pclk);
    check(yfirst, 1'b1);
    pass_on(64'h0, 1'b0);
    // freeze holds off a new command until cleared
    apb(1'b1, sois_pkg::CTRL_OFF, 32'h1);
    rd_chk(sois_pkg::CTRL_OFF, 32'h1, 32'hffff_ffff);
    cmd_set(5'b10000, 64'h0);
    refused;
    apb(1'b1, sois_pkg::CTRL_OFF, 32'h0);
    cmd_wait;
    pass_on(64'h0, 1'b0);
    print_verdict;
  end
endmodule // scalar_operand_input_stage_tb_top
`default_nettype wire
